// ### rtl/sol_config.sv
// What this block does
// - Select 100 targets output divider word
// - Select 101 targets lock pin word only
// - D23 feedback source, default fundamental
// - D22..D20 output divider, 111 reserved
// - D19..D12 band divisor, zero not allowed
// - Band logic clock is reference tick divided
// - D11 powers down oscillator, default zero
// - D10 mutes outputs until lock detected
// - D9 selects second output source
// - D8 enables second output, needs first
// - D5 clear disables both outputs
// - Two power fields, default code 10
// - Lock pin mode: low, lock, high
// - Lock indicator reflects loop lock judgement
`timescale 1ns/1ps
`default_nettype none
`include "sol_defines.svh"

module sol_config (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic spi_clk,
  input wire logic spi_data,
  input wire logic spi_le,
  input wire logic ref_tick,
  input wire logic lock_detected,
  output sol_pkg::sol_out_cfg_type out_cfg_r,
  output logic first_out_oe_r,
  output logic second_out_oe_r,
  output logic band_clk_tick_r,
  output logic lock_pin_r
);

  // ==========================================================
  // Serial word receiver
  // ==========================================================

  sol_pkg::sol_rx_type rx_r; // Shift register, bit count, edge history
  sol_pkg::sol_rx_type rx_nxt;
  logic sclk_rise; // Rising edge of serial clock
  logic le_rise; // Rising edge of latch enable
  logic word_done; // Complete word latched this cycle
  logic [2:0] word_sel; // Select field of the latched word

  assign sclk_rise = spi_clk && !rx_r.sclk_prev;
  assign le_rise = spi_le && !rx_r.le_prev;
  assign word_done = le_rise && (rx_r.count == `SOL_WORD_BITS);
  assign word_sel = rx_r.shift[`SOL_SEL_MSB:`SOL_SEL_LSB];

  // Next receiver state: shift MSB first, count saturates
  always_comb begin
    rx_nxt = rx_r;
    rx_nxt.sclk_prev = spi_clk;
    rx_nxt.le_prev = spi_le;
    if (le_rise) begin
      // Latch closes the word, next word starts from zero
      rx_nxt.count = 6'd0;
    end else if (sclk_rise && !spi_le) begin
      rx_nxt.shift = {rx_r.shift[30:0], spi_data};
      if (rx_r.count != 6'd63) begin
        rx_nxt.count = rx_r.count + 6'd1;
      end
    end
  end

  // Receiver registers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rx_r <= '0;
    end else if (clk_en) begin
      rx_r <= rx_nxt;
    end
  end

  // ==========================================================
  // Configuration words
  // ==========================================================

  sol_pkg::sol_out_cfg_type cfg_nxt;
  logic [1:0] lock_mode_r; // Lock pin mode
  logic [1:0] lock_mode_nxt;
  logic [31:0] w; // Word being applied

  assign w = rx_r.shift;

  // Decode a completed word into the selected register
  always_comb begin
    cfg_nxt = out_cfg_r;
    lock_mode_nxt = lock_mode_r;
    if (word_done && word_sel == `SOL_SEL_OUTPUT_DIV) begin
      // Bits 31..24 are reserved and dropped
      cfg_nxt.feedback_source_sel = w[`SOL_FBK_BIT];
      if (w[`SOL_RFDIV_MSB:`SOL_RFDIV_LSB] != `SOL_RFDIV_RESERVED) begin
        // Reserved ratio code keeps the previous ratio
        cfg_nxt.output_divider_code = w[`SOL_RFDIV_MSB:`SOL_RFDIV_LSB];
      end
      if (w[`SOL_BDIV_MSB:`SOL_BDIV_LSB] != 8'h00) begin
        // Zero divisor is refused, previous divisor stays
        cfg_nxt.band_clock_divisor = w[`SOL_BDIV_MSB:`SOL_BDIV_LSB];
      end
      cfg_nxt.oscillator_powerdown = w[`SOL_OSC_PD_BIT];
      cfg_nxt.mute_until_locked = w[`SOL_MUTE_BIT];
      cfg_nxt.second_out_source_sel = w[`SOL_B_SRC_BIT];
      cfg_nxt.second_out_enable = w[`SOL_B_EN_BIT];
      cfg_nxt.second_out_power = w[`SOL_B_PWR_MSB:`SOL_B_PWR_LSB];
      cfg_nxt.first_out_enable = w[`SOL_A_EN_BIT];
      cfg_nxt.first_out_power = w[`SOL_A_PWR_MSB:`SOL_A_PWR_LSB];
    end else if (word_done && word_sel == `SOL_SEL_LOCK_PIN) begin
      // Bits 19 and 20 are the host's duty and not checked
      lock_mode_nxt = w[`SOL_LPM_MSB:`SOL_LPM_LSB];
    end
  end

  // Configuration registers with documented defaults
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      out_cfg_r.feedback_source_sel <= `SOL_RST_FBK;
      out_cfg_r.output_divider_code <= `SOL_RST_RFDIV;
      out_cfg_r.band_clock_divisor <= `SOL_RST_BDIV;
      out_cfg_r.oscillator_powerdown <= 1'b0;
      out_cfg_r.mute_until_locked <= 1'b0;
      out_cfg_r.second_out_source_sel <= 1'b0;
      out_cfg_r.second_out_enable <= 1'b0;
      out_cfg_r.second_out_power <= `SOL_RST_PWR;
      out_cfg_r.first_out_enable <= 1'b0;
      out_cfg_r.first_out_power <= `SOL_RST_PWR;
      lock_mode_r <= `SOL_RST_LPM;
    end else if (clk_en) begin
      out_cfg_r <= cfg_nxt;
      lock_mode_r <= lock_mode_nxt;
    end
  end

  // ==========================================================
  // Output gating and lock pin
  // ==========================================================

  logic muted; // Outputs held off waiting for lock
  logic first_oe_nxt;
  logic second_oe_nxt;
  logic lock_pin_nxt;

  // Enables follow the registered configuration and lock level
  always_comb begin
    muted = out_cfg_r.mute_until_locked && !lock_detected;
    first_oe_nxt = out_cfg_r.first_out_enable && !muted;
    second_oe_nxt = out_cfg_r.second_out_enable && out_cfg_r.first_out_enable && !muted;
    unique case (lock_mode_r)
      `SOL_LPM_DIGITAL: lock_pin_nxt = lock_detected;
      `SOL_LPM_HIGH: lock_pin_nxt = 1'b1;
      default: lock_pin_nxt = 1'b0;
    endcase
  end

  // Output enable and lock pin registers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      first_out_oe_r <= 1'b0;
      second_out_oe_r <= 1'b0;
      lock_pin_r <= 1'b0;
    end else if (clk_en) begin
      first_out_oe_r <= first_oe_nxt;
      second_out_oe_r <= second_oe_nxt;
      lock_pin_r <= lock_pin_nxt;
    end
  end

  // ==========================================================
  // Band select clock divider
  // ==========================================================

  logic [7:0] band_cnt_r; // Reference ticks since last band tick
  logic [7:0] band_cnt_nxt;
  logic band_tick_nxt;

  // One band tick per divisor reference ticks
  always_comb begin
    band_cnt_nxt = band_cnt_r;
    band_tick_nxt = 1'b0;
    if (ref_tick) begin
      if (band_cnt_r >= out_cfg_r.band_clock_divisor - 8'd1) begin
        band_cnt_nxt = 8'd0;
        band_tick_nxt = 1'b1;
      end else begin
        band_cnt_nxt = band_cnt_r + 8'd1;
      end
    end
  end

  // Divider registers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      band_cnt_r <= 8'd0;
      band_clk_tick_r <= 1'b0;
    end else if (clk_en) begin
      band_cnt_r <= band_cnt_nxt;
      band_clk_tick_r <= band_tick_nxt;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  out_word_apply_a: assert property (clk_en && word_done && word_sel == `SOL_SEL_OUTPUT_DIV |=>
    out_cfg_r.oscillator_powerdown == $past(rx_r.shift[`SOL_OSC_PD_BIT]) &&
    out_cfg_r.first_out_enable == $past(rx_r.shift[`SOL_A_EN_BIT]))
    else $error("output word not applied");
  lock_word_only_a: assert property (clk_en && word_done && word_sel == `SOL_SEL_LOCK_PIN |=>
    $stable(out_cfg_r) && lock_mode_r == $past(rx_r.shift[`SOL_LPM_MSB:`SOL_LPM_LSB]))
    else $error("lock word misapplied");
  partial_word_a: assert property (!(clk_en && word_done) |=> $stable(out_cfg_r) && $stable(lock_mode_r))
    else $error("config changed without full word");
  zero_divisor_a: assert property (out_cfg_r.band_clock_divisor != 8'h00)
    else $error("band divisor zero");
  reserved_ratio_a: assert property (out_cfg_r.output_divider_code != `SOL_RFDIV_RESERVED)
    else $error("reserved divider code stored");
  second_needs_first_a: assert property (clk_en && !out_cfg_r.first_out_enable |=> !second_out_oe_r && !first_out_oe_r)
    else $error("second output on without first");
  mute_hold_a: assert property (clk_en && out_cfg_r.mute_until_locked && !lock_detected |=> !first_out_oe_r)
    else $error("output on while muted");
  lock_pin_mode_a: assert property (clk_en && lock_mode_r == `SOL_LPM_DIGITAL |=> lock_pin_r == $past(lock_detected))
    else $error("lock pin not following lock");
  band_tick_a: assert property (clk_en && ref_tick && out_cfg_r.band_clock_divisor == 8'h01 |=> band_clk_tick_r)
    else $error("band tick missing at divide by one");

endmodule : sol_config

`default_nettype wire

// ### rtl/sol_defines.svh
`ifndef SOL_DEFINES_SVH
`define SOL_DEFINES_SVH

// Word select codes in the low three bits
`define SOL_SEL_LSB 0
`define SOL_SEL_MSB 2
`define SOL_SEL_OUTPUT_DIV 3'h4
`define SOL_SEL_LOCK_PIN 3'h5

// Output and divider word field positions
`define SOL_FBK_BIT 23
`define SOL_RFDIV_MSB 22
`define SOL_RFDIV_LSB 20
`define SOL_BDIV_MSB 19
`define SOL_BDIV_LSB 12
`define SOL_OSC_PD_BIT 11
`define SOL_MUTE_BIT 10
`define SOL_B_SRC_BIT 9
`define SOL_B_EN_BIT 8
`define SOL_B_PWR_MSB 7
`define SOL_B_PWR_LSB 6
`define SOL_A_EN_BIT 5
`define SOL_A_PWR_MSB 4
`define SOL_A_PWR_LSB 3

// Lock pin word field positions
`define SOL_LPM_MSB 22
`define SOL_LPM_LSB 21

// Reset values
`define SOL_RST_FBK 1'b1
`define SOL_RST_RFDIV 3'h0
`define SOL_RST_BDIV 8'h01
`define SOL_RST_PWR 2'h2
`define SOL_RST_LPM 2'h1

// Encodings
`define SOL_RFDIV_RESERVED 3'h7
`define SOL_LPM_DIGITAL 2'h1
`define SOL_LPM_HIGH 2'h3

// Serial word length and band clock ceiling
`define SOL_WORD_BITS 6'd32
`define SOL_BAND_CLK_MAX_KHZ 125

`endif

// ### rtl/sol_pkg.sv
package sol_pkg;

  // Decoded output and divider configuration
  typedef struct packed {
    logic feedback_source_sel;
    logic [2:0] output_divider_code;
    logic [7:0] band_clock_divisor;
    logic oscillator_powerdown;
    logic mute_until_locked;
    logic second_out_source_sel;
    logic second_out_enable;
    logic [1:0] second_out_power;
    logic first_out_enable;
    logic [1:0] first_out_power;
  } sol_out_cfg_type;

  // Serial receiver state
  typedef struct packed {
    logic [31:0] shift;
    logic [5:0] count;
    logic sclk_prev;
    logic le_prev;
  } sol_rx_type;

endpackage : sol_pkg

// ### verification/sol_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ====
// Host side serial writer
module sol_host_model (
  input wire logic core_clk,
  output logic spi_clk,
  output logic spi_data,
  output logic spi_le
);
  // Idle lines at time zero
  initial begin
    spi_clk = 1'b0;
    spi_data = 1'b0;
    spi_le = 1'b0;
  end

  // Shift bits MSB first, select code last, then pulse latch enable
  task automatic send_word(input logic [31:0] w, input int nbits);
    for (int i = 0; i < nbits; i++) begin
      @(negedge core_clk);
      spi_clk = 1'b0;
      spi_data = w[31 - i];
      @(negedge core_clk);
      spi_clk = 1'b1;
    end
    @(negedge core_clk);
    spi_clk = 1'b0;
    spi_data = ~spi_data; // Released line shows no stale bit
    @(negedge core_clk);
    spi_le = 1'b1;
    @(negedge core_clk);
    spi_le = 1'b0;
  endtask : send_word
endmodule : sol_host_model

`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// ====
// Top level bench
module tb_top;
  typedef struct packed {logic [31:0] w; logic [1:0] oe;} sol_tb_row_type;
  logic core_clk, resetn, clk_en, ref_tick, lock_detected; // Stimulus
  logic spi_clk, spi_data, spi_le; // Serial lines
  sol_pkg::sol_out_cfg_type out_cfg_r, exp_cfg; // Seen and expected config
  logic first_out_oe_r, second_out_oe_r, band_clk_tick_r, lock_pin_r;
  logic [1:0] exp_mode; // Expected lock pin mode
  int n_fail = 0;
  int checked = 0;
  int ticks;
  // Word and expected output enables; divisors stay low enough for fast mode
  sol_tb_row_type rows [5] = '{'{32'h0060_3b3c, 2'b11},
    '{32'hfff0_0144, 2'b00},
    '{32'h0000_0023, 2'b00},
    '{32'h0000_14ac, 2'b10}, '{32'h0000_34ac, 2'b10}};

  sol_config sol_config_inst (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .spi_clk(spi_clk),
    .spi_data(spi_data), .spi_le(spi_le), .ref_tick(ref_tick), .lock_detected(lock_detected),
    .out_cfg_r(out_cfg_r), .first_out_oe_r(first_out_oe_r), .second_out_oe_r(second_out_oe_r),
    .band_clk_tick_r(band_clk_tick_r), .lock_pin_r(lock_pin_r));
  sol_host_model sol_host_model_inst (.core_clk(core_clk), .spi_clk(spi_clk), .spi_data(spi_data),
    .spi_le(spi_le));

  // Clock of 40 ns
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ====
  // Checking and reference model
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  // Update expected words from a complete word
  function automatic void apply(input logic [31:0] w);
    if (w[2:0] == 3'h4) begin
      exp_cfg.feedback_source_sel = w[23];
      if (w[22:20] != 3'h7) exp_cfg.output_divider_code = w[22:20];
      if (w[19:12] != 8'h00) exp_cfg.band_clock_divisor = w[19:12];
      exp_cfg[8:0] = w[11:3];
    end
    if (w[2:0] == 3'h5) exp_mode = w[22:21];
  endfunction : apply

  // Compare config, output enables and lock pin with the reference
  task automatic chk_out();
    logic a;
    a = exp_cfg.first_out_enable & (~exp_cfg.mute_until_locked | lock_detected);
    chk("config", out_cfg_r, exp_cfg);
    chk("first oe", first_out_oe_r, a);
    chk("second oe", second_out_oe_r, a & exp_cfg.second_out_enable);
    chk("lock pin", lock_pin_r, exp_mode == 2'h3 || (exp_mode == 2'h1 && lock_detected));
  endtask : chk_out

  task automatic send(input logic [31:0] w, input int n);
    sol_host_model_inst.send_word(w, n);
    if (n == 32) apply(w);
    repeat (3) @(negedge core_clk);
  endtask : send

  // Reset for 12 cycles, then defaults
  task automatic do_reset();
    resetn = 1'b0;
    repeat (12) @(negedge core_clk);
    resetn = 1'b1;
    exp_cfg = '{1'b1, 3'h0, 8'h01, 1'b0, 1'b0, 1'b0, 1'b0, 2'h2, 1'b0, 2'h2};
    exp_mode = 2'h1;
    @(negedge core_clk);
    chk_out();
    $display("test reset done");
  endtask : do_reset

  // ====
  // Main sequence
  initial begin
    resetn = 1'b0;
    ref_tick = 1'b0;
    clk_en = 1'b1;
    lock_detected = 1'b1;
    do_reset();
    foreach (rows[i]) begin
      send(rows[i].w, 32);
      chk("row oe", {first_out_oe_r, second_out_oe_r}, rows[i].oe);
      chk_out();
    end
    $display("test rows done");
    // Six reference pulses through divisor three, then through divisor one
    for (int d = 0; d < 2; d++) begin
      if (d == 1) begin
        send(32'h0000_14ac, 32);
      end
      ticks = 0;
      for (int k = 0; k < 28; k++) begin
        @(negedge core_clk);
        ticks += band_clk_tick_r;
        ref_tick = (k % 4 == 0) && (k < 24);
      end
      chk("band ticks", ticks, (d == 0) ? 2 : 6);
    end
    $display("test band clock done");
    // Lock lost while muting is on
    lock_detected = 1'b0;
    repeat (2) @(negedge core_clk);
    chk_out();
    $display("test mute done");
    // Every lock pin mode, lock lost and present
    for (int m = 0; m < 4; m++) begin
      send(32'h0018_0005 | (m << 21), 32);
      for (int l = 0; l < 2; l++) begin
        lock_detected = l[0];
        repeat (2) @(negedge core_clk);
        chk_out();
      end
    end
    $display("test lock pin done");
    // Clock enable low freezes the outputs and drops a whole word
    clk_en = 1'b0;
    lock_detected = 1'b0;
    sol_host_model_inst.send_word(32'h0000_0004, 32);
    chk("frozen oe", first_out_oe_r, 1'b1);
    chk("frozen config", out_cfg_r, exp_cfg);
    clk_en = 1'b1;
    repeat (2) @(negedge core_clk);
    chk_out();
    $display("test clock enable done");
    // A word one bit short is dropped, though its last bits carry select 100
    send(32'h0000_0048, 31);
    chk_out();
    $display("test short word done");
    do_reset();
    give_verdict();
  end

  // Watchdog well beyond the expected run
  initial begin
    #(40 * 6000);
    n_fail++;
    $display("test watchdog expired");
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
